// >>> shared/pwm_chan_pkg.sv
// Purpose: constants and types for the pulse width channel update block
// Assumes: APB register access, 32-bit data, word aligned registers
// Notes: all offsets are byte addresses
package pwm_chan_pkg;
	localparam int cnt_w = 16;
	localparam logic [7:0] off_ctrl = 8'h00;
	localparam logic [7:0] off_enable = 8'h04;
	localparam logic [7:0] off_disable = 8'h08;
	localparam logic [7:0] off_status = 8'h0c;
	localparam logic [7:0] off_period = 8'h10;
	localparam logic [7:0] off_duty = 8'h14;
	localparam logic [7:0] off_update = 8'h18;
	localparam logic [7:0] off_counter = 8'h1c;
	localparam logic [7:0] off_irq_stat = 8'h20;
	localparam logic [7:0] off_irq_mask = 8'h24;
	localparam int ctrl_upd_sel_bit = 0;
	localparam int ctrl_pre_lsb = 8;
	localparam int pre_w = 8;
	localparam int irq_period_bit = 0;
	localparam int irq_update_bit = 1;
	localparam int irq_w = 2;
	localparam logic [cnt_w-1:0] period_rst = 16'h0000;
	localparam logic [cnt_w-1:0] duty_rst = 16'h0000;
	localparam logic [cnt_w-1:0] cnt_first = 16'h0000;
	localparam logic [cnt_w-1:0] cnt_next = 16'h0001;
	typedef struct packed {
		logic upd_duty;
		logic [pre_w-1:0] prescale;
	} chan_cfg_t;
endpackage

// >>> rtl/pulse_width_channel_update.sv
// Purpose: one left-aligned pulse width channel with buffered period/duty update
// Assumes: APB slave, single clock clk_sys, synchronous active-high reset
// Notes: status bit keeps first-revision quirk on a too-early disable
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module pulse_width_channel_update import pwm_chan_pkg::*; (
	input wire logic clk_sys, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	output logic pwm_out, // Channel output
	output logic irq // Interrupt level
);
	// ----------------------------------------
	// Register state
	// ----------------------------------------
	chan_cfg_t cfg_q, cfg_d;
	logic [cnt_w-1:0] period_q, period_d, duty_q, duty_d, upd_q, upd_d;
	logic upd_pend_q, upd_pend_d, upd_duty_q, upd_duty_d;
	logic [cnt_w-1:0] channel_counter_value_q, channel_counter_value_d;
	logic run_q, run_d, channel_enabled_flag_q, channel_enabled_flag_d;
	logic first_q, first_d, tick_seen_q, tick_seen_d;
	logic [pre_w-1:0] pre_q, pre_d;
	logic [irq_w-1:0] istat_q, istat_d, imask_q, imask_d;
	logic [31:0] prdata_d;
	logic pready_d, pslverr_d, out_d, irq_d;
	logic wr, rd, tick, period_end, hit;
	logic [irq_w-1:0] ev;
	assign wr = psel && penable && pwrite && !pready;
	assign rd = psel && penable && !pwrite && !pready;
	assign hit = (paddr == off_ctrl) || (paddr == off_enable) || (paddr == off_disable) ||
		(paddr == off_status) || (paddr == off_period) || (paddr == off_duty) ||
		(paddr == off_update) || (paddr == off_counter) || (paddr == off_irq_stat) ||
		(paddr == off_irq_mask);
	assign tick = run_q && (pre_q == cfg_q.prescale);
	assign period_end = tick && (channel_counter_value_q >= period_q);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		cfg_d = cfg_q;
		period_d = period_q;
		duty_d = duty_q;
		upd_d = upd_q;
		upd_pend_d = upd_pend_q;
		upd_duty_d = upd_duty_q;
		channel_counter_value_d = channel_counter_value_q;
		run_d = run_q;
		channel_enabled_flag_d = channel_enabled_flag_q;
		first_d = first_q;
		tick_seen_d = tick_seen_q;
		pre_d = pre_q;
		imask_d = imask_q;
		ev = '0;
		pready_d = psel && penable && !pready;
		pslverr_d = psel && penable && !pready && !hit;
		prdata_d = '0;
		// Channel clock prescaler
		if (run_q) begin
			pre_d = tick ? '0 : pre_q + 1'b1;
		end
		if (tick) begin
			tick_seen_d = 1'b1;
			if (period_end) begin
				ev[irq_period_bit] = 1'b1;
				first_d = 1'b0;
				channel_counter_value_d = cnt_next;
				if (upd_pend_q) begin
					upd_pend_d = 1'b0;
					ev[irq_update_bit] = 1'b1;
					if (upd_duty_q) begin
						duty_d = upd_q;
					end else if (period_q != '0) begin
						period_d = upd_q;
					end
				end
			end else begin
				channel_counter_value_d = channel_counter_value_q + 1'b1;
			end
		end
		if (wr) begin
			unique case (paddr)
				off_ctrl: begin
					cfg_d.upd_duty = pwdata[ctrl_upd_sel_bit];
					cfg_d.prescale = pwdata[ctrl_pre_lsb +: pre_w];
				end
				off_enable: if (pwdata[0] && !run_q) begin
					run_d = 1'b1;
					channel_enabled_flag_d = 1'b1;
					first_d = 1'b1;
					tick_seen_d = 1'b0;
					pre_d = '0;
					channel_counter_value_d = cnt_first;
				end
				off_disable: if (pwdata[0]) begin
					run_d = 1'b0;
					// Early disable leaves the flag set, matching silicon
					channel_enabled_flag_d = tick_seen_q ? 1'b0 : channel_enabled_flag_q;
				end
				off_period: period_d = pwdata[cnt_w-1:0];
				off_duty: duty_d = pwdata[cnt_w-1:0];
				off_update: begin
					if (channel_counter_value_q <= cnt_next) begin
						upd_pend_d = 1'b0;
						if (cfg_q.upd_duty) begin
							duty_d = pwdata[cnt_w-1:0];
						end else if (period_q != '0) begin
							period_d = pwdata[cnt_w-1:0];
						end
					end else begin
						upd_d = pwdata[cnt_w-1:0];
						upd_duty_d = cfg_q.upd_duty;
						upd_pend_d = 1'b1;
					end
				end
				off_irq_mask: imask_d = pwdata[irq_w-1:0];
				default: ;
			endcase
		end
		if (rd) begin
			unique case (paddr)
				off_ctrl: prdata_d = 32'({cfg_q.prescale, 7'h00, cfg_q.upd_duty});
				off_status: prdata_d = 32'(channel_enabled_flag_q);
				off_period: prdata_d = 32'(period_q);
				off_duty: prdata_d = 32'(duty_q);
				off_update: prdata_d = 32'(upd_q);
				off_counter: prdata_d = 32'(channel_counter_value_q);
				off_irq_stat: prdata_d = 32'(istat_q);
				off_irq_mask: prdata_d = 32'(imask_q);
				default: prdata_d = '0;
			endcase
		end
		// Set wins over the write-one clear
		istat_d = istat_q;
		if (wr && paddr == off_irq_stat) begin
			istat_d = istat_q & ~pwdata[irq_w-1:0];
		end
		istat_d = istat_d | ev;
		irq_d = |(istat_d & imask_d);
		out_d = run_d && (channel_counter_value_d < duty_d);
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cfg_q <= '0;
			period_q <= period_rst;
			duty_q <= duty_rst;
			upd_q <= '0;
			upd_pend_q <= 1'b0;
			upd_duty_q <= 1'b0;
			channel_counter_value_q <= cnt_first;
			run_q <= 1'b0;
			channel_enabled_flag_q <= 1'b0;
			first_q <= 1'b0;
			tick_seen_q <= 1'b0;
			pre_q <= '0;
			istat_q <= '0;
			imask_q <= '0;
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			pwm_out <= 1'b0;
			irq <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			period_q <= period_d;
			duty_q <= duty_d;
			upd_q <= upd_d;
			upd_pend_q <= upd_pend_d;
			upd_duty_q <= upd_duty_d;
			channel_counter_value_q <= channel_counter_value_d;
			run_q <= run_d;
			channel_enabled_flag_q <= channel_enabled_flag_d;
			first_q <= first_d;
			tick_seen_q <= tick_seen_d;
			pre_q <= pre_d;
			istat_q <= istat_d;
			imask_q <= imask_d;
			prdata <= prdata_d;
			pready <= pready_d;
			pslverr <= pslverr_d;
			pwm_out <= out_d;
			irq <= irq_d;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_imm_update;
		@(posedge clk_sys) disable iff (rst)
		(wr && paddr == off_update && channel_counter_value_q <= cnt_next && cfg_q.upd_duty)
		|=> (duty_q == $past(pwdata[cnt_w-1:0]));
	endproperty
	a_imm_update: assert property (p_imm_update) else $error("immediate duty update missed");
	property p_zero_period;
		@(posedge clk_sys) disable iff (rst)
		(period_q == '0 && !(wr && paddr == off_period)) |=> (period_q == '0);
	endproperty
	a_zero_period: assert property (p_zero_period) else $error("period left zero via update");
	property p_start_first;
		@(posedge clk_sys) disable iff (rst)
		(wr && paddr == off_enable && pwdata[0] && !run_q) |=> (channel_counter_value_q == cnt_first);
	endproperty
	a_start_first: assert property (p_start_first) else $error("first period not from zero");
	property p_restart_one;
		@(posedge clk_sys) disable iff (rst)
		(period_end && !wr) |=> (channel_counter_value_q == cnt_next && !first_q);
	endproperty
	a_restart_one: assert property (p_restart_one) else $error("later period not from one");
	property p_early_disable;
		@(posedge clk_sys) disable iff (rst)
		(wr && paddr == off_disable && pwdata[0] && !tick_seen_q && channel_enabled_flag_q)
		|=> (channel_enabled_flag_q && !run_q) ##1 !pwm_out;
	endproperty
	a_early_disable: assert property (p_early_disable) else $error("early disable flag wrong");
	property p_late_disable;
		@(posedge clk_sys) disable iff (rst)
		(wr && paddr == off_disable && pwdata[0] && tick_seen_q) |=> !channel_enabled_flag_q;
	endproperty
	a_late_disable: assert property (p_late_disable) else $error("disable flag not cleared");
	property p_buffered;
		@(posedge clk_sys) disable iff (rst)
		(!(wr && (paddr == off_duty || paddr == off_update)) && !period_end) |=> $stable(duty_q);
	endproperty
	a_buffered: assert property (p_buffered) else $error("duty changed mid period");
	property p_pend_apply;
		@(posedge clk_sys) disable iff (rst)
		(period_end && upd_pend_q && upd_duty_q && !wr) |=> (duty_q == $past(upd_q) && !upd_pend_q);
	endproperty
	a_pend_apply: assert property (p_pend_apply) else $error("pending update not applied");
	property p_apb_ready;
		@(posedge clk_sys) disable iff (rst)
		(psel && penable && !pready) |=> pready ##1 !pready;
	endproperty
	a_apb_ready: assert property (p_apb_ready) else $error("apb ready timing wrong");
	c_imm: cover property (@(posedge clk_sys) disable iff (rst)
		wr && paddr == off_update && channel_counter_value_q <= cnt_next);
	c_pend: cover property (@(posedge clk_sys) disable iff (rst) period_end && upd_pend_q);
	c_early: cover property (@(posedge clk_sys) disable iff (rst)
		wr && paddr == off_disable && !tick_seen_q && run_q);
	c_irq: cover property (@(posedge clk_sys) disable iff (rst) irq);
endmodule // pulse_width_channel_update

// >>> bench/tb.sv
// Purpose: self-checking bench for the pulse width channel update block
// Assumes: APB slave answers within 20 cycles, channel tick every prescale+1 cycles
// Notes: period and duty drawn from a fixed-seed shift register
`timescale 1ns/1ns
module tb import pwm_chan_pkg::*; ;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, pwm_out, irq, er, iq;
	int err_count = 0;
	int checked = 0;
	int cycles = 0;
	int k;
	logic [15:0] rnd = 16'hfb40;
	logic [cnt_w-1:0] per, dut_v;
	always #4 clk_sys = ~clk_sys;
	pulse_width_channel_update u_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pwm_out(pwm_out), .irq(irq));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function automatic logic [31:0] ctrl_word(input logic upd_duty, input logic [7:0] pre);
		return (32'(pre) << ctrl_pre_lsb) | (32'(upd_duty) << ctrl_upd_sel_bit);
	endfunction
	// First period shows duty highs, later ones duty-1, since the count restarts at 1
	function automatic int exp_hi(input int duty, input int periods);
		return duty + (periods - 1) * (duty - 1);
	endfunction
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic close_out;
		$display("Comparisons %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic do_rst(input int n);
		rst <= 1'b1;
		cyc(n);
		rst <= 1'b0;
		cyc(1);
	endtask
	// Request held until pready is seen high at a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// Answer and read data are taken at the edge that samples pready high
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		iq = irq;
		chk("pready", 32'h1, {31'h0, pready});
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge, so the next call never re-raises psel in this time step
		@(posedge clk_sys);
	endtask
	task automatic count_hi(input int n);
		k = 0;
		repeat (n) begin
			@(posedge clk_sys);
			#1;
			if (pwm_out === 1'b1)
				k++;
		end
		@(posedge clk_sys);
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		do_rst(12);
		xfer(1'b0, off_period, 32'h0);
		chk("period_rst", 32'h0, rd);
		xfer(1'b0, 8'h40, 32'h0);
		chk("unmapped_err", 32'h1, {31'h0, er});
		chk("unmapped_rd", 32'h0, rd);
		xfer(1'b1, off_update, 32'h5);
		xfer(1'b0, off_period, 32'h0);
		chk("period_zero", 32'h0, rd);
		repeat (2) begin
			rnd = lfsr(rnd);
			per = 16'd20 + 16'(rnd[3:0]);
			dut_v = 16'd1 + 16'(rnd[6:4]);
			do_rst(2);
			xfer(1'b1, off_period, 32'(per));
			xfer(1'b1, off_ctrl, ctrl_word(1'b0, 8'hff));
			xfer(1'b1, off_enable, 32'h1);
			xfer(1'b0, off_counter, 32'h0);
			chk("cnt_low", 32'h0, rd);
			xfer(1'b1, off_update, 32'(per + 16'd3));
			xfer(1'b0, off_period, 32'h0);
			chk("period_now", 32'(per + 16'd3), rd);
			xfer(1'b1, off_ctrl, ctrl_word(1'b1, 8'hff));
			xfer(1'b1, off_update, 32'(dut_v));
			xfer(1'b0, off_duty, 32'h0);
			chk("duty_now", 32'(dut_v), rd);
			do_rst(2);
			xfer(1'b1, off_period, 32'(per));
			xfer(1'b1, off_ctrl, ctrl_word(1'b1, 8'h01));
			xfer(1'b1, off_enable, 32'h1);
			cyc(12);
			xfer(1'b0, off_counter, 32'h0);
			chk("cnt_high", 32'h1, 32'(rd >= 32'h2));
			xfer(1'b1, off_update, 32'(dut_v));
			xfer(1'b0, off_duty, 32'h0);
			chk("duty_held", 32'h0, rd);
			cyc(2 * int'(per) + 8);
			xfer(1'b0, off_duty, 32'h0);
			chk("duty_late", 32'(dut_v), rd);
			xfer(1'b0, off_irq_stat, 32'h0);
			chk("irq_stat", 32'h3, rd);
			chk("irq_masked", 32'h0, {31'h0, iq});
			xfer(1'b1, off_irq_mask, 32'h2);
			xfer(1'b0, off_irq_stat, 32'h0);
			chk("irq_on", 32'h1, {31'h0, iq});
			xfer(1'b1, off_irq_stat, 32'h2);
			xfer(1'b0, off_irq_mask, 32'h0);
			chk("irq_cleared", 32'h0, {31'h0, iq});
			xfer(1'b1, off_disable, 32'h1);
			xfer(1'b0, off_status, 32'h0);
			chk("flag_off", 32'h0, rd);
			do_rst(2);
			xfer(1'b1, off_period, 32'(per));
			xfer(1'b1, off_duty, 32'(dut_v));
			fork
				xfer(1'b1, off_enable, 32'h1);
				count_hi(3 * int'(per) + 5 + int'(per) / 2);
			join
			chk("highs", 32'(exp_hi(int'(dut_v), 4)), 32'(k));
			do_rst(2);
			xfer(1'b1, off_period, 32'(per));
			xfer(1'b1, off_duty, 32'(per));
			xfer(1'b1, off_ctrl, ctrl_word(1'b0, 8'h07));
			xfer(1'b1, off_enable, 32'h1);
			xfer(1'b1, off_disable, 32'h1);
			xfer(1'b0, off_status, 32'h0);
			chk("flag_stuck", 32'h1, rd);
			count_hi(40);
			chk("out_off", 32'h0, 32'(k));
		end
		close_out;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			close_out;
		end
	end
endmodule // tb
